// *** rtl/gpef_pkg.sv ***
// Shared constants and types for the two-port general-purpose I/O block
package gpef_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] GPEF_OFS_EAST_PIN_STATE = 8'h00;
    localparam logic [7:0] GPEF_OFS_EAST_PULLUP = 8'h04;
    localparam logic [7:0] GPEF_OFS_EAST_DIR = 8'h08;
    localparam logic [7:0] GPEF_OFS_EAST_LATCH = 8'h0C;
    localparam logic [7:0] GPEF_OFS_FIFTH_DIR = 8'h10;
    localparam logic [7:0] GPEF_OFS_FIFTH_LATCH = 8'h14;
    localparam logic [7:0] GPEF_OFS_FIFTH_PIN_STATE = 8'h18;
    localparam logic [7:0] GPEF_OFS_SEG_SELECT = 8'h1C;

    // Field positions and widths
    localparam int GPEF_PORT_W = 8;
    localparam int GPEF_SEG_W = 4;
    localparam int GPEF_MODE_W = 3;
    localparam int GPEF_CLK_PIN = 7;
    localparam int GPEF_RSVD_PIN = 1;

    // Reset values
    localparam logic [7:0] GPEF_RST_EAST_PULLUP = 8'h00;
    localparam logic [7:0] GPEF_RST_EAST_DIR = 8'h00;
    localparam logic [7:0] GPEF_RST_EAST_LATCH = 8'h00;
    localparam logic [7:0] GPEF_RST_FIFTH_DIR = 8'h00;
    localparam logic [7:0] GPEF_RST_FIFTH_LATCH = 8'h00;
    localparam logic [3:0] GPEF_RST_SEG_SELECT = 4'h0;
    localparam logic GPEF_RST_CLK_DIR = 1'b1;
    localparam logic GPEF_RST_CLK_DIR_SINGLE = 1'b0;

    // Implemented bits of the fifth port: pins 7..2 and 0
    localparam logic [7:0] GPEF_FIFTH_MASK = 8'hFD;

    // Operating modes
    localparam logic [2:0] GPEF_MODE_EXP_LO = 3'h4;
    localparam logic [2:0] GPEF_MODE_EXP_HI = 3'h6;
    localparam logic [2:0] GPEF_MODE_SINGLE = 3'h7;

    // Segment-select value that keeps the pins as a port
    localparam logic [3:0] GPEF_SEG_PORT = 4'h0;

    // Synchroniser depth for pins
    localparam int GPEF_SYNC_STAGES = 3;

    // AXI responses
    localparam logic [1:0] GPEF_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPEF_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        GPEF_REG_EAST_PIN_STATE,
        GPEF_REG_EAST_PULLUP,
        GPEF_REG_EAST_DIR,
        GPEF_REG_EAST_LATCH,
        GPEF_REG_FIFTH_DIR,
        GPEF_REG_FIFTH_LATCH,
        GPEF_REG_FIFTH_PIN_STATE,
        GPEF_REG_SEG_SELECT,
        GPEF_REG_NONE
    } gpef_reg_t;

endpackage

// *** rtl/gpef_sync.sv ***
// Three-stage pin synchroniser with agree-to-change output register
`timescale 1ns/100ps
module gpef_sync import gpef_pkg::*; #(
    parameter int WIDTH = 8,
    parameter bit USE_RESET = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous input and settled output
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;

    // Pipeline carries no reset so straps pass through while reset is held
    always_ff @(posedge aclk) begin
        stage1_reg <= async_in;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
    end

    // A bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (USE_RESET && !aresetn) begin
                    out_reg[i] <= 1'b0;
                end else if (stage2_reg[i] == stage3_reg[i]) begin
                    out_reg[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = out_reg;
endmodule // gpef_sync

// *** rtl/gpef_axil.sv ***
// AXI4-Lite slave front end producing a register write strobe and the read address
`timescale 1ns/100ps
module gpef_axil import gpef_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
    logic arready_reg, rvalid_reg, rvalid_next;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic aw_hs, w_hs, ar_hs;

    assign aw_hs = s_axi_awvalid && awready_reg;
    assign w_hs = s_axi_wvalid && wready_reg;
    assign ar_hs = s_axi_arvalid && arready_reg;
    // Address and data may arrive in either order; write once both are held
    assign wr_en = aw_full_reg && w_full_reg && !bvalid_reg;
    assign aw_full_next = aw_hs ? 1'b1 : (wr_en ? 1'b0 : aw_full_reg);
    assign w_full_next = w_hs ? 1'b1 : (wr_en ? 1'b0 : w_full_reg);
    assign bvalid_next = wr_en ? 1'b1 : ((bvalid_reg && s_axi_bready) ? 1'b0 : bvalid_reg);
    assign rvalid_next = ar_hs ? 1'b1 : ((rvalid_reg && s_axi_rready) ? 1'b0 : rvalid_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= GPEF_RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= !aw_full_next;
            wready_reg <= !w_full_next;
            bvalid_reg <= bvalid_next;
            if (wr_en) begin
                bresp_reg <= wr_err ? GPEF_RESP_SLVERR : GPEF_RESP_OKAY;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    // Read data is captured at the address handshake edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= GPEF_RESP_OKAY;
        end else begin
            arready_reg <= !rvalid_next && !ar_hs;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= rd_data;
                rresp_reg <= rd_err ? GPEF_RESP_SLVERR : GPEF_RESP_OKAY;
            end
        end
    end

    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = s_axi_araddr;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule // gpef_axil

// *** rtl/gpef_top.sv ***
// Two general-purpose ports: east (8 pins) and fifth (7 pins) with register access
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module gpef_top import gpef_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Mode straps
    input wire logic [2:0] mode_pins,
    input wire logic bus16_pin,
    // East port pins
    input wire logic [7:0] east_pin_i,
    output logic [7:0] east_pin_o,
    output logic [7:0] east_pin_oe,
    output logic [7:0] east_pullup_en,
    // External data bus low byte and segment drive
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_oe,
    output logic [7:0] ext_data_in,
    input wire logic [7:0] segment_outputs_low,
    // Fifth port pins
    input wire logic [7:0] fifth_pin_i,
    output logic [7:0] fifth_pin_o,
    output logic [7:0] fifth_pin_oe
);
    logic wr_en;
    logic wr_err;
    logic rd_err;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic [3:0] wr_strb;
    logic [2:0] mode_q;
    logic bus16_q;
    logic [7:0] east_pin_q;
    logic [7:0] fifth_pin_q;
    gpef_reg_t wr_sel;
    gpef_reg_t rd_sel;
    logic lane0;

    logic [7:0] east_pullup_ctrl_reg;
    logic [7:0] east_direction_bits_reg;
    logic [7:0] east_output_latch_reg;
    logic [7:0] fifth_port_direction_bits_reg;
    logic [7:0] fifth_port_output_latch_reg;
    logic [3:0] segment_select_field_reg;
    logic clk_phase_reg;
    logic [7:0] east_pin_o_reg;
    logic [7:0] east_pin_oe_reg;
    logic [7:0] east_pullup_en_reg;
    logic [7:0] ext_data_in_reg;
    logic [7:0] fifth_pin_o_reg;
    logic [7:0] fifth_pin_oe_reg;

    logic mode_exp;
    logic mode_single;
    logic seg_on;
    logic bus_data;
    logic [7:0] east_pin_state;
    logic [7:0] fifth_pin_state;

    function automatic gpef_reg_t gpef_decode(input logic [7:0] addr);
        gpef_reg_t sel;
        sel = GPEF_REG_NONE;
        case (addr)
            GPEF_OFS_EAST_PIN_STATE: sel = GPEF_REG_EAST_PIN_STATE;
            GPEF_OFS_EAST_PULLUP: sel = GPEF_REG_EAST_PULLUP;
            GPEF_OFS_EAST_DIR: sel = GPEF_REG_EAST_DIR;
            GPEF_OFS_EAST_LATCH: sel = GPEF_REG_EAST_LATCH;
            GPEF_OFS_FIFTH_DIR: sel = GPEF_REG_FIFTH_DIR;
            GPEF_OFS_FIFTH_LATCH: sel = GPEF_REG_FIFTH_LATCH;
            GPEF_OFS_FIFTH_PIN_STATE: sel = GPEF_REG_FIFTH_PIN_STATE;
            GPEF_OFS_SEG_SELECT: sel = GPEF_REG_SEG_SELECT;
            default: sel = GPEF_REG_NONE;
        endcase
        return sel;
    endfunction

    gpef_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Straps must pass while reset is held, so no reset on this path
    gpef_sync #(.WIDTH(GPEF_MODE_W + 1), .USE_RESET(1'b0)) u_sync_mode (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({bus16_pin, mode_pins}),
        .sync_out({bus16_q, mode_q})
    );

    // Pins reset to zero so no stale level reads back after reset
    gpef_sync #(.WIDTH(2 * GPEF_PORT_W), .USE_RESET(1'b1)) u_sync_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({fifth_pin_i, east_pin_i}),
        .sync_out({fifth_pin_q, east_pin_q})
    );

    // Straps are used only once settled, never raw
    assign mode_exp = (mode_q >= GPEF_MODE_EXP_LO) && (mode_q <= GPEF_MODE_EXP_HI);
    assign mode_single = (mode_q == GPEF_MODE_SINGLE);
    assign seg_on = (segment_select_field_reg != GPEF_SEG_PORT);
    assign bus_data = mode_exp && bus16_q && !seg_on;
    assign wr_sel = gpef_decode(wr_addr);
    assign rd_sel = gpef_decode(rd_addr);
    assign lane0 = wr_strb[0];
    // Unmapped offsets answer with an error and change nothing
    assign wr_err = (wr_sel == GPEF_REG_NONE);
    assign rd_err = (rd_sel == GPEF_REG_NONE);

    // Output pins read back the latch, input pins read the pin
    assign east_pin_state = (east_direction_bits_reg & east_output_latch_reg) |
                            (~east_direction_bits_reg & east_pin_q);
    assign fifth_pin_state = ((fifth_port_direction_bits_reg & fifth_port_output_latch_reg) |
                              (~fifth_port_direction_bits_reg & fifth_pin_q)) & GPEF_FIFTH_MASK;

    // Write-only registers read as zero, standing in for an undefined value
    always_comb begin
        rd_data = 32'h00000000;
        unique case (rd_sel)
            GPEF_REG_EAST_PIN_STATE: rd_data[7:0] = east_pin_state;
            GPEF_REG_EAST_PULLUP: rd_data[7:0] = east_pullup_ctrl_reg;
            GPEF_REG_EAST_DIR: rd_data[7:0] = 8'h00;
            GPEF_REG_EAST_LATCH: rd_data[7:0] = east_output_latch_reg;
            GPEF_REG_FIFTH_DIR: rd_data[7:0] = 8'h00;
            GPEF_REG_FIFTH_LATCH: rd_data[7:0] = fifth_port_output_latch_reg & GPEF_FIFTH_MASK;
            GPEF_REG_FIFTH_PIN_STATE: rd_data[7:0] = fifth_pin_state;
            GPEF_REG_SEG_SELECT: rd_data[3:0] = segment_select_field_reg;
            GPEF_REG_NONE: rd_data = 32'h00000000;
        endcase
    end

    // East registers; the pin-state offset decodes but stores nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            east_pullup_ctrl_reg <= GPEF_RST_EAST_PULLUP;
            east_direction_bits_reg <= GPEF_RST_EAST_DIR;
            east_output_latch_reg <= GPEF_RST_EAST_LATCH;
        end else if (wr_en && lane0) begin
            unique case (wr_sel)
                GPEF_REG_EAST_PULLUP: east_pullup_ctrl_reg <= wr_data[7:0];
                GPEF_REG_EAST_DIR: east_direction_bits_reg <= wr_data[7:0];
                GPEF_REG_EAST_LATCH: east_output_latch_reg <= wr_data[7:0];
                GPEF_REG_EAST_PIN_STATE: east_output_latch_reg <= east_output_latch_reg;
                GPEF_REG_FIFTH_DIR, GPEF_REG_FIFTH_LATCH, GPEF_REG_FIFTH_PIN_STATE,
                GPEF_REG_SEG_SELECT, GPEF_REG_NONE: east_pullup_ctrl_reg <= east_pullup_ctrl_reg;
            endcase
        end
    end

    // Fifth-port registers; reserved bit 1 is never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifth_port_direction_bits_reg <= GPEF_RST_FIFTH_DIR;
            fifth_port_direction_bits_reg[GPEF_CLK_PIN] <= mode_single ?
                GPEF_RST_CLK_DIR_SINGLE : GPEF_RST_CLK_DIR;
            fifth_port_output_latch_reg <= GPEF_RST_FIFTH_LATCH;
        end else if (wr_en && lane0) begin
            if (wr_sel == GPEF_REG_FIFTH_DIR) begin
                fifth_port_direction_bits_reg <= wr_data[7:0] & GPEF_FIFTH_MASK;
            end
            if (wr_sel == GPEF_REG_FIFTH_LATCH) begin
                fifth_port_output_latch_reg <= wr_data[7:0] & GPEF_FIFTH_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            segment_select_field_reg <= GPEF_RST_SEG_SELECT;
        end else if (wr_en && lane0 && (wr_sel == GPEF_REG_SEG_SELECT)) begin
            segment_select_field_reg <= wr_data[3:0];
        end
    end

    // Registered pins cannot carry aclk itself; the clock pin gets aclk/2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_phase_reg <= 1'b0;
        end else begin
            clk_phase_reg <= !clk_phase_reg;
        end
    end

    // East pin drive and pull-ups, segment use taking priority over the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            east_pin_o_reg <= 8'h00;
            east_pin_oe_reg <= 8'h00;
            east_pullup_en_reg <= 8'h00;
            ext_data_in_reg <= 8'h00;
        end else begin
            ext_data_in_reg <= east_pin_q;
            if (seg_on) begin
                east_pin_o_reg <= segment_outputs_low;
                east_pin_oe_reg <= 8'hFF;
                east_pullup_en_reg <= 8'h00;
            end else if (bus_data) begin
                east_pin_o_reg <= ext_data_out;
                east_pin_oe_reg <= {GPEF_PORT_W{ext_data_oe}};
                east_pullup_en_reg <= 8'h00;
            end else begin
                east_pin_o_reg <= east_output_latch_reg;
                east_pin_oe_reg <= east_direction_bits_reg;
                east_pullup_en_reg <= ((mode_exp || mode_single) ? 8'hFF : 8'h00) &
                                      ~east_direction_bits_reg & east_pullup_ctrl_reg;
            end
        end
    end

    // Fifth pin drive: clock on pin 7, latch elsewhere, bit 1 idle
    genvar i;
    generate
        for (i = 0; i < GPEF_PORT_W; i++) begin : g_fifth
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    fifth_pin_o_reg[i] <= 1'b0;
                    fifth_pin_oe_reg[i] <= 1'b0;
                end else if (i == GPEF_CLK_PIN) begin
                    fifth_pin_o_reg[i] <= clk_phase_reg;
                    fifth_pin_oe_reg[i] <= fifth_port_direction_bits_reg[i];
                end else if (i == GPEF_RSVD_PIN) begin
                    fifth_pin_o_reg[i] <= 1'b0;
                    fifth_pin_oe_reg[i] <= 1'b0;
                end else begin
                    fifth_pin_o_reg[i] <= fifth_port_output_latch_reg[i];
                    fifth_pin_oe_reg[i] <= fifth_port_direction_bits_reg[i];
                end
            end
        end
    endgenerate

    assign east_pin_o = east_pin_o_reg;
    assign east_pin_oe = east_pin_oe_reg;
    assign east_pullup_en = east_pullup_en_reg;
    assign ext_data_in = ext_data_in_reg;
    assign fifth_pin_o = fifth_pin_o_reg;
    assign fifth_pin_oe = fifth_pin_oe_reg;
endmodule // gpef_top

// *** sim/gpef_top_sva.sv ***
// Port-level checker for the two-port I/O block
`timescale 1ns/100ps
module gpef_top_sva import gpef_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Straps and pins
    input wire logic [2:0] mode_pins,
    input wire logic bus16_pin,
    input wire logic [7:0] east_pin_oe,
    input wire logic [7:0] east_pullup_en,
    input wire logic [7:0] fifth_pin_o,
    input wire logic [7:0] fifth_pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic aw_w;
    assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    a_pullup_input: assert property ((east_pullup_en & east_pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    // Strap must settle through the synchroniser first
    a_bus16_nopull: assert property ((bus16_pin && mode_pins >= 3'h4 && mode_pins <= 3'h6)[*6]
        |-> east_pullup_en == 8'h00) else $error("pull-up in wide bus mode");
    a_rsvd_idle: assert property (fifth_pin_oe[1] == 1'b0 && fifth_pin_o[1] == 1'b0)
        else $error("reserved pin active");
    a_clk_toggle: assert property (fifth_pin_oe[7] && $past(fifth_pin_oe[7])
        |-> fifth_pin_o[7] != $past(fifth_pin_o[7])) else $error("clock pin not toggling");
    a_clkdir_reset: assert property ($rose(aresetn) |-> ##[1:2] fifth_pin_oe[7] == (mode_pins != 3'h7))
        else $error("clock pin direction wrong after reset");
    a_aw_drop: assert property (aw_w |=> !s_axi_awready && !s_axi_wready)
        else $error("ready stayed high after accept");
    a_bresp_time: assert property (aw_w |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rvalid_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_wo_zero: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr == 8'h08
        || s_axi_araddr == 8'h10) |=> s_axi_rdata == 32'h0) else $error("write-only read not zero");
endmodule // gpef_top_sva
bind gpef_top gpef_top_sva i_sva (.*);

// *** sim/gpef_pins_model.sv ***
// Board-side model of the pins of both ports
`timescale 1ns/100ps
module gpef_pins_model (
    // Clock
    input wire logic aclk,
    // Design drive
    input wire logic [7:0] east_pin_o,
    input wire logic [7:0] east_pin_oe,
    input wire logic [7:0] east_pullup_en,
    input wire logic [7:0] fifth_pin_o,
    input wire logic [7:0] fifth_pin_oe,
    // Board drive
    input wire logic [7:0] board_drv,
    input wire logic [7:0] board_val,
    input wire logic [7:0] fifth_val,
    // Pin levels
    output logic [7:0] east_pin_i,
    output logic [7:0] fifth_pin_i
);
    logic [7:0] east_last = 8'h00;
    always @(posedge aclk) begin
        east_last <= east_pin_i;
    end
    // Floating pins wander so a stale level never passes
    assign east_pin_i = (east_pin_oe & east_pin_o) | (~east_pin_oe & board_drv & board_val)
        | (~east_pin_oe & ~board_drv & (east_pullup_en | ~east_last));
    assign fifth_pin_i = (fifth_pin_oe & fifth_pin_o) | (~fifth_pin_oe & fifth_val);
endmodule // gpef_pins_model

// *** sim/tb_top.sv ***
// Self-checking bench for the two-port I/O block
`timescale 1ns/100ps
module tb_top import gpef_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] mode_pins = 3'h4;
    logic bus16_pin = 1'b0, ext_data_oe = 1'b1;
    logic [7:0] ext_data_out = 8'h5A, segment_outputs_low = 8'hC3;
    logic [7:0] board_drv = 8'h0C, board_val = 8'h04, fifth_val = 8'h02;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] east_pin_i, east_pin_o, east_pin_oe, east_pullup_en, ext_data_in;
    logic [7:0] fifth_pin_i, fifth_pin_o, fifth_pin_oe;
    int bad_count = 0;
    int num_checks = 0;
    always #2 aclk = ~aclk;
    gpef_top i_dut (.*);
    gpef_pins_model i_pins (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 100) begin
            bad_count++;
            tally_and_finish();
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
        repeat (3) @(posedge aclk);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 100) begin
            bad_count++;
            tally_and_finish();
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, (a > GPEF_OFS_SEG_SELECT) ? GPEF_RESP_SLVERR : GPEF_RESP_OKAY);
        @(posedge aclk);
    endtask
    // Straps change only inside reset, long enough to pass the synchroniser
    task automatic boot(input logic [2:0] m, input logic b);
        aresetn <= 1'b0;
        mode_pins <= m;
        bus16_pin <= b;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        @(posedge aclk);
        boot(3'h4, 1'b0);
        chk(fifth_pin_oe, 8'h80);
        rdx(GPEF_OFS_EAST_LATCH, 32'h0);
        rdx(GPEF_OFS_FIFTH_LATCH, 32'h0);
        wr(GPEF_OFS_EAST_DIR, 8'hF0, GPEF_RESP_OKAY);
        wr(GPEF_OFS_EAST_LATCH, 8'hA5, GPEF_RESP_OKAY);
        wr(GPEF_OFS_EAST_PULLUP, 8'h0F, GPEF_RESP_OKAY);
        repeat (6) @(posedge aclk);
        chk({east_pin_oe, east_pin_o & 8'hF0, east_pullup_en}, {8'hF0, 8'hA0, 8'h0F});
        rdx(GPEF_OFS_EAST_PIN_STATE, 32'hA7);
        rdx(GPEF_OFS_EAST_DIR, 32'h0);
        wr(GPEF_OFS_EAST_PIN_STATE, 8'h00, GPEF_RESP_OKAY);
        rdx(GPEF_OFS_EAST_PIN_STATE, 32'hA7);
        wr(GPEF_OFS_EAST_DIR, 8'hF1, GPEF_RESP_OKAY);
        chk(east_pullup_en, 8'h0E);
        wr(GPEF_OFS_FIFTH_DIR, 8'h7F, GPEF_RESP_OKAY);
        wr(GPEF_OFS_FIFTH_LATCH, 8'hFF, GPEF_RESP_OKAY);
        chk({fifth_pin_oe, fifth_pin_o & 8'h7F}, {8'h7D, 8'h7D});
        rdx(GPEF_OFS_FIFTH_LATCH, 32'hFD);
        rdx(GPEF_OFS_FIFTH_DIR, 32'h0);
        rdx(GPEF_OFS_FIFTH_PIN_STATE, 32'h7D);
        wr(GPEF_OFS_SEG_SELECT, 8'h01, GPEF_RESP_OKAY);
        chk({east_pin_oe, east_pullup_en, east_pin_o}, {8'hFF, 8'h00, 8'hC3});
        wr(8'h40, 8'h11, GPEF_RESP_SLVERR);
        rdx(8'h40, 32'h0);
        boot(3'h5, 1'b1);
        wr(GPEF_OFS_EAST_PULLUP, 8'hFF, GPEF_RESP_OKAY);
        chk({east_pin_oe, east_pullup_en, east_pin_o}, {8'hFF, 8'h00, 8'h5A});
        chk(ext_data_in, 8'h5A);
        boot(3'h7, 1'b0);
        chk(fifth_pin_oe, 8'h00);
        wr(GPEF_OFS_EAST_PULLUP, 8'hFF, GPEF_RESP_OKAY);
        chk(east_pullup_en, 8'hFF);
        tally_and_finish();
    end
endmodule // tb_top
